// File: verilog/lo_control_and_cal_trigger.v
// Contract
// - delay field 7:4 sets sclk handover time
// - delay applies only without separate lines
// - setting changes trigger automatic calibration
// - entering or leaving receive triggers calibration
// - frequency flag A or B change triggers
// - skip bit suppresses all but idle start and forced calibration
// - lock monitor continuous or post-calibration only
// - divider select: 0 divides 2, 1 divides 4
// - timing register holds main scaler bits 6:0
// - in-progress status until result valid
`include "lo_control_defines.vh"
`default_nettype none
module lo_control_and_cal_trigger #(
   parameter HANDOVER_UNIT = `HANDOVER_UNIT_CYCLES,
   parameter LOCK_WINDOW = `LOCK_WINDOW_CYCLES
) (
   input wire clk,
   input wire rst_b,
   input wire reg_wr_en,
   input wire reg_rd_en,
   input wire [`ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wr_data,
   output reg [7:0] reg_rd_data_ff,
   input wire ninth_edge,
   input wire cmd_is_tx,
   input wire cmd_is_rx,
   input wire cmd_end,
   input wire separate_transmit_lines,
   input wire separate_receive_output,
   output reg sclk_drive_start_ff,
   output reg sclk_drive_en_ff,
   input wire [7:0] freq_word_high_byte,
   input wire doubled_modulator_result,
   input wire fractional_disable,
   input wire mode_is_rx,
   input wire freq_flag_a,
   input wire freq_flag_b,
   input wire synth_start_from_idle,
   input wire force_calibration,
   input wire synth_running,
   input wire cal_done,
   output reg cal_start_ff,
   output wire calibration_in_progress,
   output reg lock_detect_enable_ff,
   output wire low_band_select,
   output wire output_divider_select,
   output reg [2:0] lo_div_ratio_ff,
   output wire [6:0] baud_main_scaler,
   output wire [7:0] baud_scaler_high
);
   // ********************************************
   // helpers
   // ********************************************
   function [2:0] div_ratio;
      input sel;
      begin
         div_ratio = sel ? `DIV_RATIO_HIGH : `DIV_RATIO_LOW;
      end
   endfunction

   function addr_hit;
      input [`ADDR_W-1:0] a;
      input [`ADDR_W-1:0] b;
      begin
         addr_hit = (a == b);
      end
   endfunction

   // ********************************************
   // register file
   // ********************************************
   reg [7:0] local_osc_control_ff;
   reg [6:0] baud_scaler_low_ff;
   reg [7:0] baud_scaler_high_ff;
   reg [7:0] nxt_rd_data;
   localparam [7:0] RST_SCALER_LOW = `RST_BAUD_SCALER_LOW;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         local_osc_control_ff <= `RST_LOCAL_OSC_CONTROL;
         baud_scaler_low_ff <= RST_SCALER_LOW[6:0];
         baud_scaler_high_ff <= `RST_BAUD_SCALER_HIGH;
      end else if (reg_wr_en) begin
         if (addr_hit(reg_addr, `OFF_LOCAL_OSC_CONTROL)) begin
            local_osc_control_ff <= reg_wr_data;
         end else if (addr_hit(reg_addr, `OFF_BAUD_SCALER_LOW)) begin
            baud_scaler_low_ff <= reg_wr_data[`BAUD_MAIN_LOW_MSB:0];
         end else if (addr_hit(reg_addr, `OFF_BAUD_SCALER_HIGH)) begin
            baud_scaler_high_ff <= reg_wr_data;
         end
      end
   end

   // unmapped addresses read zero; top bit of the scaler low register is unused
   always @* begin
      nxt_rd_data = 8'h00;
      if (addr_hit(reg_addr, `OFF_LOCAL_OSC_CONTROL)) begin
         nxt_rd_data = local_osc_control_ff;
      end else if (addr_hit(reg_addr, `OFF_BAUD_SCALER_LOW)) begin
         nxt_rd_data = {1'b0, baud_scaler_low_ff};
      end else if (addr_hit(reg_addr, `OFF_BAUD_SCALER_HIGH)) begin
         nxt_rd_data = baud_scaler_high_ff;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rd_data_ff <= 8'h00;
      end else if (reg_rd_en) begin
         reg_rd_data_ff <= nxt_rd_data;
      end
   end

   wire [3:0] clock_handover_delay = local_osc_control_ff[`LOC_DELAY_MSB:`LOC_DELAY_LSB];
   wire skip_auto_calibration = local_osc_control_ff[`LOC_SKIP_CAL];
   wire continuous_lock_monitor = local_osc_control_ff[`LOC_LOCK_MON];
   // band choice is the host's job; the bit is passed on as written
   assign low_band_select = local_osc_control_ff[`LOC_LOW_BAND];
   assign output_divider_select = local_osc_control_ff[`LOC_OUT_DIV];
   assign baud_main_scaler = baud_scaler_low_ff;
   assign baud_scaler_high = baud_scaler_high_ff;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lo_div_ratio_ff <= `DIV_RATIO_HIGH;
      end else begin
         lo_div_ratio_ff <= div_ratio(output_divider_select);
      end
   end

   // ********************************************
   // serial clock handover
   // ********************************************
   reg hand_busy_ff;
   reg [19:0] hand_cnt_ff;
   wire hand_applies = (cmd_is_tx & ~separate_transmit_lines) |
                       (cmd_is_rx & ~separate_receive_output);
   wire [19:0] hand_load = clock_handover_delay * HANDOVER_UNIT[15:0];

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hand_busy_ff <= 1'b0;
         hand_cnt_ff <= 20'h0_0000;
         sclk_drive_start_ff <= 1'b0;
         sclk_drive_en_ff <= 1'b0;
      end else begin
         sclk_drive_start_ff <= 1'b0;
         if (cmd_end) begin
            sclk_drive_en_ff <= 1'b0;
         end
         // a new ninth edge wins over an end in the same cycle
         if (ninth_edge && hand_applies) begin
            hand_busy_ff <= 1'b1;
            hand_cnt_ff <= hand_load;
         end else if (cmd_end) begin
            hand_busy_ff <= 1'b0;
         end else if (hand_busy_ff) begin
            if (hand_cnt_ff == 20'h0_0000) begin
               hand_busy_ff <= 1'b0;
               sclk_drive_start_ff <= 1'b1;
               sclk_drive_en_ff <= 1'b1;
            end else begin
               hand_cnt_ff <= hand_cnt_ff - 20'h0_0001;
            end
         end
      end
   end

   // ********************************************
   // calibration triggers
   // ********************************************
   wire setting_changed;
   wire mode_changed;
   wire flag_changed;

   setting_change_detect #(.W(12)) u_setting_change (
      .clk(clk),
      .rst_b(rst_b),
      .cur({freq_word_high_byte, low_band_select, output_divider_select,
            doubled_modulator_result, fractional_disable}),
      .changed(setting_changed)
   );

   setting_change_detect #(.W(1)) u_mode_change (
      .clk(clk),
      .rst_b(rst_b),
      .cur(mode_is_rx),
      .changed(mode_changed)
   );

   setting_change_detect #(.W(2)) u_flag_change (
      .clk(clk),
      .rst_b(rst_b),
      .cur({freq_flag_a, freq_flag_b}),
      .changed(flag_changed)
   );

   // skip only masks the change triggers; idle start and forced runs always go
   wire auto_trig = (setting_changed | mode_changed | flag_changed) & ~skip_auto_calibration;
   wire cal_trig = auto_trig | synth_start_from_idle | force_calibration;

   // ********************************************
   // calibration sequencer
   // ********************************************
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN = 2'b10;
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg pending_ff;
   reg nxt_pending;
   reg nxt_cal_start;

   // a trigger during a run is kept and starts a new run once the current one is done, so no change is missed
   always @* begin
      nxt_state = state_ff;
      nxt_pending = pending_ff;
      nxt_cal_start = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (cal_trig || pending_ff) begin
               nxt_state = ST_RUN;
               nxt_pending = 1'b0;
               nxt_cal_start = 1'b1;
            end
         end
         ST_RUN: begin
            if (cal_trig) begin
               nxt_pending = 1'b1;
            end
            if (cal_done) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
            nxt_pending = 1'b0;
         end
      endcase
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= ST_IDLE;
         pending_ff <= 1'b0;
         cal_start_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         pending_ff <= nxt_pending;
         cal_start_ff <= nxt_cal_start;
      end
   end

   // request in flight counts as running; result valid only once this drops
   assign calibration_in_progress = state_ff[1] | pending_ff | cal_trig;

   // ********************************************
   // lock detector gating
   // ********************************************
   reg [15:0] lock_cnt_ff;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lock_cnt_ff <= 16'h0000;
         lock_detect_enable_ff <= 1'b0;
      end else begin
         if (cal_done) begin
            lock_cnt_ff <= LOCK_WINDOW[15:0];
         end else if (lock_cnt_ff != 16'h0000) begin
            lock_cnt_ff <= lock_cnt_ff - 16'h0001;
         end
         lock_detect_enable_ff <= continuous_lock_monitor ? synth_running :
                                  (cal_done | (lock_cnt_ff != 16'h0000));
      end
   end
endmodule // lo_control_and_cal_trigger
`default_nettype wire

// File: verilog/lo_control_defines.vh
`ifndef LO_CONTROL_DEFINES_VH
`define LO_CONTROL_DEFINES_VH
// ********************************************
// register offsets
// ********************************************
`define ADDR_W 6
`define OFF_LOCAL_OSC_CONTROL 6'h0D
`define OFF_BAUD_SCALER_LOW 6'h0E
`define OFF_BAUD_SCALER_HIGH 6'h0F
// ********************************************
// field positions of local_osc_control and of the scaler low register
// ********************************************
`define LOC_DELAY_MSB 7
`define LOC_DELAY_LSB 4
`define LOC_SKIP_CAL 3
`define LOC_LOCK_MON 2
`define LOC_LOW_BAND 1
`define LOC_OUT_DIV 0
`define BAUD_MAIN_LOW_MSB 6
// ********************************************
// reset values
// ********************************************
`define RST_LOCAL_OSC_CONTROL 8'h01
`define RST_BAUD_SCALER_LOW 8'h00
`define RST_BAUD_SCALER_HIGH 8'h00
// ********************************************
// timing counts and divider ratios
// ********************************************
`define HANDOVER_UNIT_CYCLES 16'h0001
`define LOCK_WINDOW_CYCLES 16'h0040
`define DIV_RATIO_LOW 3'h2
`define DIV_RATIO_HIGH 3'h4
`endif

// File: verilog/setting_change_detect.v
`default_nettype none
// compares each setting with its value one cycle earlier
module setting_change_detect #(
   parameter W = 8
) (
   input wire clk,
   input wire rst_b,
   input wire [W-1:0] cur,
   output wire changed
);
   reg [W-1:0] prev_ff;
   reg armed_ff;

   // first cycle after reset has no history, so it never reports a change
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_ff <= {W{1'b0}};
         armed_ff <= 1'b0;
      end else begin
         prev_ff <= cur;
         armed_ff <= 1'b1;
      end
   end

   assign changed = armed_ff & (|(cur ^ prev_ff));
endmodule // setting_change_detect
`default_nettype wire

// File: sim/lo_cal_monitor.sv
`default_nettype none
module lo_cal_monitor (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wr_data,
   input wire logic [7:0] reg_rd_data_ff,
   input wire logic ninth_edge,
   input wire logic cmd_is_tx,
   input wire logic cmd_end,
   input wire logic separate_transmit_lines,
   input wire logic sclk_drive_start_ff,
   input wire logic sclk_drive_en_ff,
   input wire logic mode_is_rx,
   input wire logic freq_flag_a,
   input wire logic synth_start_from_idle,
   input wire logic synth_running,
   input wire logic cal_start_ff,
   input wire logic calibration_in_progress,
   input wire logic lock_detect_enable_ff,
   input wire logic output_divider_select,
   input wire logic [2:0] lo_div_ratio_ff,
   input wire logic [6:0] baud_main_scaler
);
   timeunit 1ns;
   timeprecision 1ps;
   // *****
   // shadow of the control register
   // *****
   logic [7:0] loc_ff;
   logic armed_ff;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         loc_ff <= 8'h01;
         armed_ff <= 1'b0;
      end else begin
         armed_ff <= 1'b1;
         if (reg_wr_en && reg_addr == 6'h0D) loc_ff <= reg_wr_data;
      end
   end
   default clocking @(posedge clk); endclocking
   // skip the first edge: detectors only arm then
   default disable iff (!rst_b);
   sequence s_take;
      ninth_edge && cmd_is_tx && !separate_transmit_lines && loc_ff[7:4] == 4'h0;
   endsequence
   sequence s_quiet;
      !cmd_end && !ninth_edge;
   endsequence
   chk_hand_zero: assert property (s_take ##1 s_quiet |=> sclk_drive_start_ff)
      else $error("handover late");
   chk_start_en: assert property (sclk_drive_start_ff |-> sclk_drive_en_ff)
      else $error("start without enable");
   chk_rx_trig: assert property (armed_ff && $changed(mode_is_rx) && !loc_ff[3] |-> calibration_in_progress)
      else $error("rx switch missed");
   chk_flag_trig: assert property (armed_ff && $changed(freq_flag_a) && !loc_ff[3] |-> calibration_in_progress)
      else $error("flag change missed");
   chk_idle_start: assert property (synth_start_from_idle |-> calibration_in_progress)
      else $error("idle start missed");
   chk_cal_launch: assert property ($rose(calibration_in_progress) |=> cal_start_ff)
      else $error("no cal start");
   chk_div_ratio: assert property (lo_div_ratio_ff == ($past(output_divider_select) ? 3'h4 : 3'h2))
      else $error("divider ratio");
   chk_lock_cont: assert property (loc_ff[2] && $past(loc_ff[2])
      |-> lock_detect_enable_ff == $past(synth_running))
      else $error("lock enable");
   chk_baud_low: assert property (reg_wr_en && reg_addr == 6'h0E
      |=> baud_main_scaler == $past(reg_wr_data[6:0]))
      else $error("scaler bits");
   chk_rd_unmap: assert property (reg_rd_en && !(reg_addr inside {[6'h0D:6'h0F]}) |=> reg_rd_data_ff == 8'h00)
      else $error("unmapped read");
endmodule // lo_cal_monitor
bind lo_control_and_cal_trigger lo_cal_monitor u_mon (.clk(clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en),
   .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data_ff(reg_rd_data_ff),
   .ninth_edge(ninth_edge), .cmd_is_tx(cmd_is_tx), .cmd_end(cmd_end),
   .separate_transmit_lines(separate_transmit_lines), .sclk_drive_start_ff(sclk_drive_start_ff),
   .sclk_drive_en_ff(sclk_drive_en_ff), .mode_is_rx(mode_is_rx), .freq_flag_a(freq_flag_a),
   .synth_start_from_idle(synth_start_from_idle), .synth_running(synth_running), .cal_start_ff(cal_start_ff),
   .calibration_in_progress(calibration_in_progress), .lock_detect_enable_ff(lock_detect_enable_ff),
   .output_divider_select(output_divider_select), .lo_div_ratio_ff(lo_div_ratio_ff),
   .baud_main_scaler(baud_main_scaler));
`default_nettype wire

// File: sim/cal_engine_model.sv
`default_nettype none
// calibration engine: answers after lat+1 cycles
module cal_engine_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic [3:0] lat,
   output logic done_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] cnt_ff;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= 5'h00;
         done_ff <= 1'b0;
      end else begin
         done_ff <= (cnt_ff == 5'h01);
         if (start) cnt_ff <= {1'b0, lat} + 5'h01;
         else if (cnt_ff != 5'h00) cnt_ff <= cnt_ff - 5'h01;
      end
   end
endmodule // cal_engine_model
`default_nettype wire

// File: sim/lo_control_and_cal_trigger_tb.sv
`default_nettype none
module lo_control_and_cal_trigger_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_b = 0, wr = 0, rd = 0, nin = 0, tx = 0, rx = 0, ce = 0, stx = 0, srx = 0;
   logic dmr = 0, fd = 0, mrx = 0, fa = 0, fb = 0, ssi = 0, run = 0, fc = 0;
   logic [5:0] addr = 0;
   logic [7:0] wdat = 0, fwh = 0, rdat, bsh;
   logic [3:0] lat = 0;
   logic sst, sen, cst, cip, lde, lbs, ods, done;
   logic [2:0] ratio;
   logic [6:0] bms;
   logic [31:0] seed = 32'h0000_005B;
   int regs[3] = '{8'h01, 0, 0};
   int fail_count = 0, n_checks = 0, n, skip;
   lo_control_and_cal_trigger #(.LOCK_WINDOW(4)) DUT (.clk(clk), .rst_b(rst_b), .reg_wr_en(wr),
      .reg_rd_en(rd), .reg_addr(addr), .reg_wr_data(wdat), .reg_rd_data_ff(rdat), .ninth_edge(nin),
      .cmd_is_tx(tx), .cmd_is_rx(rx), .cmd_end(ce), .separate_transmit_lines(stx),
      .separate_receive_output(srx), .sclk_drive_start_ff(sst), .sclk_drive_en_ff(sen),
      .freq_word_high_byte(fwh), .doubled_modulator_result(dmr), .fractional_disable(fd),
      .mode_is_rx(mrx), .freq_flag_a(fa), .freq_flag_b(fb), .synth_start_from_idle(ssi),
      .force_calibration(fc), .synth_running(run), .cal_done(done), .cal_start_ff(cst),
      .calibration_in_progress(cip), .lock_detect_enable_ff(lde), .low_band_select(lbs),
      .output_divider_select(ods), .lo_div_ratio_ff(ratio), .baud_main_scaler(bms), .baud_scaler_high(bsh));
   cal_engine_model eng (.clk(clk), .rst_b(rst_b), .start(cst), .lat(lat), .done_ff(done));
   always #4 clk = ~clk;
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input bit ok, input string m);
      n_checks++;
      if (!ok) begin
         fail_count++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   task automatic wait_sig(input int k, input int lim, input bit must, output int c);
      c = 0;
      while ((k == 0 ? sst : k == 1 ? cst : !cip) !== 1'b1 && c < lim) begin
         @(posedge clk);
         #1 c++;
      end
      if (must && c >= lim) begin
         chk(0, "wait limit");
         close_out();
      end
   endtask
   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk) begin wr <= 1; addr <= a; wdat <= d; end
      @(posedge clk) wr <= 0;
      if (a inside {[6'h0D:6'h0F]}) regs[a - 13] = d;
   endtask
   task automatic rd_reg(input logic [5:0] a);
      logic [7:0] e;
      e = (a inside {[6'h0D:6'h0F]}) ? regs[a - 13] : 8'h00;
      if (a == 6'h0E) e[7] = 1'b0;
      @(posedge clk) begin rd <= 1; addr <= a; end
      @(posedge clk) rd <= 0;
      #1 chk(rdat === e, "read data");
   endtask
   task automatic poke(input int k);
      @(posedge clk) begin
         lat <= xs() % 8;
         case (k)
            0: mrx <= !mrx;
            1: fa <= !fa;
            2: fb <= !fb;
            3: fwh <= fwh ^ (xs() | 8'h01);
            4: dmr <= !dmr;
            5: fd <= !fd;
            6: ssi <= 1;
            default: fc <= 1;
         endcase
      end
      @(posedge clk) begin ssi <= 0; fc <= 0; end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1;
      for (int a = 12; a < 17; a++) rd_reg(a);
      for (int i = 0; i < 3; i++) begin
         wr_reg(6'h0E, xs());
         wr_reg(6'h0F, xs());
         rd_reg(6'h0E);
         rd_reg(6'h0F);
         chk(bms === regs[1][6:0] && bsh === regs[2][7:0], "scaler ports");
      end
      $display("test registers done");
      for (int i = 0; i < 12; i++) begin
         int dv, isrx, sep;
         dv = (i % 3) * 3;
         isrx = (i / 3) % 2;
         sep = i / 6;
         wr_reg(6'h0D, {dv[3:0], 4'h1});
         @(posedge clk) begin nin <= 1; tx <= !isrx; rx <= isrx; stx <= sep ^ isrx; srx <= sep ^ !isrx; end
         @(posedge clk) nin <= 0;
         #1 wait_sig(0, 20, !sep, n);
         chk(n == (sep ? 20 : dv + 1) && sen === !sep, "handover");
         @(posedge clk) ce <= 1;
         @(posedge clk) ce <= 0;
      end
      $display("test handover done");
      for (int k = 0; k < 16; k++) begin
         skip = k / 8;
         if (k % 8 == 0) wr_reg(6'h0D, {4'h0, skip[0], 3'b001});
         poke(k % 8);
         #1 chk(cst === (!skip || k % 8 >= 6), "cal start");
         wait_sig(2, 40, 1, n);
         chk(n == ((!skip || k % 8 >= 6) ? lat + 3 : 0), "cal busy");
         if (!skip || k % 8 >= 6) chk(lde === 1'b1, "lock window open");
      end
      $display("test calibration done");
      wr_reg(6'h0D, 8'h00);
      @(posedge clk);
      #1 chk(ratio === 3'h2 && cip === 1'b1, "divide by two");
      wait_sig(2, 40, 1, n);
      repeat (4) @(posedge clk);
      #1 chk(lde === 1'b1, "lock window held");
      @(posedge clk);
      #1 chk(lde === 1'b0, "lock window closed");
      wr_reg(6'h0D, 8'h05);
      @(posedge clk);
      #1 chk(ratio === 3'h4 && ods === 1'b1 && lbs === 1'b0, "divide by four");
      wait_sig(2, 40, 1, n);
      @(posedge clk) run <= 1;
      @(posedge clk);
      #1 chk(lde === 1'b1, "lock follow");
      $display("test divider and lock done");
      close_out();
   end
endmodule // lo_control_and_cal_trigger_tb
`default_nettype wire
